/* logic/scm_params.svh */
/*
  Offsets, reset values and timing counts of the system clock and
  mode control block. Assumes a 200 MHz block clock.
*/
`ifndef SCM_PARAMS_SVH
`define SCM_PARAMS_SVH

// ----------------------------------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------------------------------
`define SCM_OFF_CTRL     8'h00
`define SCM_OFF_OSC      8'h04
`define SCM_OFF_MODE     8'h08
`define SCM_OFF_IRQ_STS  8'h0c
`define SCM_OFF_IRQ_MSK  8'h10

// ----------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------
`define SCM_SEL_HI       7
`define SCM_SEL_LO       5
`define SCM_HS_KEEP_BIT  1
`define SCM_LS_KEEP_BIT  0
`define SCM_STABLE_BIT   1
`define SCM_HS_EN_BIT    0
`define SCM_CTRL_RST     8'h00
`define SCM_HS_EN_RST    1'b1
`define SCM_SEL_SUB      3'h7

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define SCM_CLK_HZ       200000000
`define SCM_FAST_HZ      8000000
`define SCM_SLOW_HZ      32000
`define SCM_FAST_PER     (`SCM_CLK_HZ / `SCM_FAST_HZ)
`define SCM_SLOW_PER     (`SCM_CLK_HZ / `SCM_SLOW_HZ)
`define SCM_HS_STAB_NS   16000
`define SCM_HS_STAB_CYC  ((`SCM_HS_STAB_NS * 200 + 999) / 1000)

`endif

/* logic/scm_pkg.sv */
/*
  Types of the system clock and mode control block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
`default_nettype none
package scm_pkg;
  typedef enum logic [2:0] {
    SCM_RUN,
    SCM_SLEEP,
    SCM_IDLE_SLOW,
    SCM_IDLE_BOTH,
    SCM_IDLE_FAST
  } scm_mode_t;

  typedef enum logic [1:0] {
    SCM_SW_IDLE,
    SCM_SW_OLD1,
    SCM_SW_OLD2,
    SCM_SW_NEW
  } scm_sw_t;
endpackage
`default_nettype wire

/* logic/scm_osc.sv */
/*
  Model of one internal RC oscillator as a tick pulse on the block clock,
  with a stabilisation flag. Assumes en_i comes from the same clock.
*/
`default_nettype none
module scm_osc #(
  parameter int PERIOD = 25,
  parameter int STAB   = 1
) (
  input  wire logic clk_i,    // Block clock
  input  wire logic rst_i,    // Sync reset
  input  wire logic en_i,     // Oscillator enable
  output logic      tick_o,   // One pulse per period
  output logic      stable_o  // Stabilised
);
  logic [15:0] per_q;
  logic [15:0] stab_q;

  // ----------------------------------------------------------------
  // Period counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      per_q  <= 16'h0000;
      tick_o <= 1'b0;
    end else if (per_q == 16'(PERIOD - 1)) begin
      per_q  <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      per_q  <= per_q + 16'h0001;
      tick_o <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Stabilisation: restarts whenever the oscillator is stopped
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      stab_q   <= 16'h0000;
      stable_o <= 1'b0;
    end else if (stab_q >= 16'(STAB - 1)) begin
      stable_o <= 1'b1;
    end else begin
      stab_q <= stab_q + 16'h0001;
    end
  end
endmodule
`default_nettype wire

/* logic/scm_top.sv */
/*
  System clock selection and power mode control, Wishbone classic slave.
  Assumes halt_i, wake_i and wdt_en_i are driven by logic on clk_i.
*/
// What this block does
// - Fast internal RC is sole fast source
// - Slow internal RC is sole slow source
// - Oscillators also feed watchdog and time base
// - Both oscillator classes always have a source
// - NORMAL: select 0-6 divides fast clock
// - SLOW: select 7 runs system on sub
// - SLOW: fast runs per enable, feeds peripherals
// - Halt with keeps 00 enters SLEEP
// - SLEEP: slow RC runs only with watchdog
// - Halt keeps 01: idle, slow only
// - Halt keeps 11: idle, both clocks on
// - Halt keeps 10: idle, fast only
// - NORMAL keeps fast RC running whatever its enable
// - Select codes map to divide 1..64, sub
// - Enabling fast clears then sets stable flag
// - Watchdog enable keeps slow RC running
`default_nettype none
`include "scm_params.svh"
module scm_top #(
  parameter int SLOW_PER = `SCM_SLOW_PER
) (
  input  wire logic        clk_i,         // 200 MHz clock
  input  wire logic        rst_i,         // Sync reset, high
  input  wire logic        wb_cyc_i,      // Wishbone cycle
  input  wire logic        wb_stb_i,      // Wishbone strobe
  input  wire logic        wb_we_i,       // Write
  input  wire logic [7:0]  wb_adr_i,      // Byte address
  input  wire logic [3:0]  wb_sel_i,      // Byte lanes
  input  wire logic [31:0] wb_dat_i,      // Write data
  output logic      [31:0] wb_dat_o,      // Read data
  output logic             wb_ack_o,      // Acknowledge
  input  wire logic        halt_i,        // CPU halt pulse
  input  wire logic        wake_i,        // Wake pulse
  input  wire logic        wdt_en_i,      // Watchdog enabled
  output logic             cpu_run_o,     // CPU clocked
  output logic             sys_clk_en_o,  // System clock tick
  output logic             fast_clk_en_o, // Fast clock tick
  output logic             sub_clk_en_o,  // Sub clock tick
  output logic             slow_internal_rc_clk_en_o, // Raw slow tick, watchdog
  output logic [6:0]       periph_en_o,   // Fast divided 1..64
  output scm_pkg::scm_mode_t mode_o,      // Operating mode
  output logic             irq_o          // Interrupt
);
  import scm_pkg::*;

  localparam int FAST_PER = `SCM_FAST_PER;
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  scm_mode_t   mode_q;
  scm_sw_t     sw_q;
  logic [2:0]  sel_q, sel_act_q, sel_tgt_q;
  logic [2:0]  sts_q, msk_q, ev;
  logic [5:0]  div_q;
  logic        hs_keep_q, ls_keep_q, hs_en_q, stable_d_q;
  logic        fast_on, slow_on, fast_tick, slow_tick, hs_stable;
  logic        old_tick, new_tick, old_dead, sys_pass, sw_emit, wr;

  // ----------------------------------------------------------------
  // Tick selection
  // ----------------------------------------------------------------
  function automatic logic sel_tick(input logic [2:0] s, input logic f,
                                    input logic l, input logic [5:0] c);
    logic [5:0] m;
    m = 6'((7'h01 << s) - 7'h01);
    if (s == `SCM_SEL_SUB)
      sel_tick = l;
    else
      sel_tick = f && ((c & m) == m);
  endfunction

  // ----------------------------------------------------------------
  // Oscillators
  // ----------------------------------------------------------------
  scm_osc #(.PERIOD(FAST_PER), .STAB(`SCM_HS_STAB_CYC)) u_fast (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (fast_on),
    .tick_o  (fast_tick),
    .stable_o(hs_stable)
  );

  scm_osc #(.PERIOD(SLOW_PER), .STAB(1)) u_slow (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .en_i    (slow_on),
    .tick_o  (slow_tick),
    .stable_o()
  );

  always_comb begin
    // NORMAL forces the fast RC on whatever the enable bit says
    fast_on = 1'b0;
    unique case (mode_q)
      SCM_RUN:       fast_on = (sel_q != `SCM_SEL_SUB) || hs_en_q ||
                               (sel_act_q != `SCM_SEL_SUB);
      SCM_IDLE_BOTH: fast_on = 1'b1;
      SCM_IDLE_FAST: fast_on = 1'b1;
      SCM_IDLE_SLOW: fast_on = 1'b0;
      SCM_SLEEP:     fast_on = 1'b0;
    endcase
  end

  always_comb begin
    slow_on = wdt_en_i;
    unique case (mode_q)
      SCM_RUN, SCM_IDLE_SLOW, SCM_IDLE_BOTH: slow_on = 1'b1;
      // Sub clock is gated here, but watchdog and time base still need the RC
      SCM_IDLE_FAST:                         slow_on = 1'b1;
      SCM_SLEEP:                             slow_on = wdt_en_i;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      div_q <= 6'h00;
    else if (fast_tick)
      div_q <= div_q + 6'h01;
  end

  always_comb begin
    for (int k = 0; k < 7; k++)
      periph_en_o[k] = sel_tick(3'(k), fast_tick, 1'b0, div_q);
  end

  assign fast_clk_en_o = fast_tick;
  assign slow_internal_rc_clk_en_o = slow_tick;
  assign sub_clk_en_o  = slow_tick && (mode_q == SCM_RUN || mode_q == SCM_IDLE_SLOW ||
                                       mode_q == SCM_IDLE_BOTH);
  assign cpu_run_o     = (mode_q == SCM_RUN);
  assign mode_o        = mode_q;

  // ----------------------------------------------------------------
  // Glitch-free switch: one old period, then one new period, silent
  // ----------------------------------------------------------------
  assign old_tick = sel_tick(sel_act_q, fast_tick, slow_tick, div_q);
  assign new_tick = sel_tick(sel_tgt_q, fast_tick, slow_tick, div_q);
  assign old_dead = (sel_act_q != `SCM_SEL_SUB) && !fast_on;
  assign sw_emit  = (sw_q == SCM_SW_IDLE) || (sw_q == SCM_SW_OLD1);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sw_q      <= SCM_SW_IDLE;
      sel_act_q <= 3'h0;
      sel_tgt_q <= 3'h0;
    end else if (mode_q == SCM_RUN) begin
      unique case (sw_q)
        SCM_SW_IDLE: if (sel_q != sel_act_q) begin
          sel_tgt_q <= sel_q;
          sw_q      <= SCM_SW_OLD1;
        end
        SCM_SW_OLD1: if (old_dead)
          sw_q <= SCM_SW_NEW;
        else if (old_tick)
          sw_q <= SCM_SW_OLD2;
        SCM_SW_OLD2: if (old_tick || old_dead)
          sw_q <= SCM_SW_NEW;
        SCM_SW_NEW: if (new_tick) begin
          sel_act_q <= sel_tgt_q;
          sw_q      <= SCM_SW_IDLE;
        end
      endcase
    end
  end

  always_comb begin
    sys_pass = 1'b0;
    unique case (mode_q)
      SCM_RUN:       sys_pass = sw_emit;
      SCM_IDLE_BOTH: sys_pass = 1'b1;
      SCM_IDLE_SLOW: sys_pass = (sel_act_q == `SCM_SEL_SUB);
      SCM_IDLE_FAST: sys_pass = (sel_act_q != `SCM_SEL_SUB);
      SCM_SLEEP:     sys_pass = 1'b0;
    endcase
  end

  assign sys_clk_en_o = sys_pass && old_tick;

  // ----------------------------------------------------------------
  // Operating mode
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i)
      mode_q <= SCM_RUN;
    else if (mode_q == SCM_RUN && halt_i) begin
      unique case ({hs_keep_q, ls_keep_q})
        2'b00: mode_q <= SCM_SLEEP;
        2'b01: mode_q <= SCM_IDLE_SLOW;
        2'b11: mode_q <= SCM_IDLE_BOTH;
        2'b10: mode_q <= SCM_IDLE_FAST;
      endcase
    end else if (mode_q != SCM_RUN && wake_i)
      mode_q <= SCM_RUN;
  end

  // ----------------------------------------------------------------
  // Wishbone slave, one wait state
  // ----------------------------------------------------------------
  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
      wb_dat_o <= 32'h0000_0000;
      unique case (wb_adr_i)
        `SCM_OFF_CTRL:    wb_dat_o <= {24'h000000, sel_q, 3'h0, hs_keep_q, ls_keep_q};
        `SCM_OFF_OSC:     wb_dat_o <= {30'h0, hs_stable, hs_en_q};
        `SCM_OFF_MODE:    wb_dat_o <= {25'h0, sel_act_q, 1'b0, mode_q};
        `SCM_OFF_IRQ_STS: wb_dat_o <= {29'h0, sts_q};
        `SCM_OFF_IRQ_MSK: wb_dat_o <= {29'h0, msk_q};
        default:          wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sel_q     <= 3'(`SCM_CTRL_RST >> `SCM_SEL_LO);
      hs_keep_q <= 1'b0;
      ls_keep_q <= 1'b0;
    end else if (wr && wb_adr_i == `SCM_OFF_CTRL) begin
      sel_q     <= wb_dat_i[`SCM_SEL_HI:`SCM_SEL_LO];
      hs_keep_q <= wb_dat_i[`SCM_HS_KEEP_BIT];
      ls_keep_q <= wb_dat_i[`SCM_LS_KEEP_BIT];
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i)
      hs_en_q <= `SCM_HS_EN_RST;
    else if (wr && wb_adr_i == `SCM_OFF_OSC)
      hs_en_q <= wb_dat_i[`SCM_HS_EN_BIT];
  end

  // ----------------------------------------------------------------
  // Interrupts: set beats write-one-to-clear
  // ----------------------------------------------------------------
  always_ff @(posedge clk_i) begin
    if (rst_i)
      stable_d_q <= 1'b0;
    else
      stable_d_q <= hs_stable;
  end

  assign ev = {mode_q != SCM_RUN && wake_i, mode_q == SCM_RUN && halt_i,
               hs_stable && !stable_d_q};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sts_q <= 3'h0;
      msk_q <= 3'h0;
    end else begin
      if (wr && wb_adr_i == `SCM_OFF_IRQ_STS)
        sts_q <= (sts_q & ~wb_dat_i[2:0]) | ev;
      else
        sts_q <= sts_q | ev;
      if (wr && wb_adr_i == `SCM_OFF_IRQ_MSK)
        msk_q <= wb_dat_i[2:0];
    end
  end

  assign irq_o = |(sts_q & msk_q);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  logic [15:0] gap_q;

  always_ff @(posedge clk_i) begin
    if (rst_i)
      gap_q <= 16'hffff;
    else if (sys_clk_en_o)
      gap_q <= 16'h0000;
    else if (gap_q != 16'hffff)
      gap_q <= gap_q + 16'h0001;
  end

  property p_sleep;
    mode_q == SCM_RUN && halt_i && !hs_keep_q && !ls_keep_q |=> mode_q == SCM_SLEEP && !cpu_run_o;
  endproperty
  a_sleep: assert property (p_sleep) else $error("halt with keeps 00 did not sleep");
  // Second sleep cycle on: the last oscillator tick has drained, a wake may follow
  property p_sleep_quiet;
    mode_q == SCM_SLEEP ##1 mode_q == SCM_SLEEP |-> !sys_clk_en_o && !sub_clk_en_o && !fast_clk_en_o;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("clock ticking in sleep");
  property p_sleep_wdt;
    mode_q == SCM_SLEEP |-> slow_on == wdt_en_i;
  endproperty
  a_sleep_wdt: assert property (p_sleep_wdt) else $error("slow RC not following watchdog");
  property p_wdt_keep;
    wdt_en_i && !ls_keep_q |-> slow_on;
  endproperty
  a_wdt_keep: assert property (p_wdt_keep) else $error("slow RC off with watchdog on");
  property p_idle_slow;
    mode_q == SCM_RUN && halt_i && !hs_keep_q && ls_keep_q
      |=> mode_q == SCM_IDLE_SLOW ##1 !fast_clk_en_o && (sys_clk_en_o -> sel_act_q == `SCM_SEL_SUB);
  endproperty
  a_idle_slow: assert property (p_idle_slow) else $error("slow-only idle wrong");
  property p_idle_both;
    mode_q == SCM_IDLE_BOTH |-> fast_on && slow_on && !cpu_run_o;
  endproperty
  a_idle_both: assert property (p_idle_both) else $error("both-on idle stopped a clock");
  property p_idle_fast;
    mode_q == SCM_IDLE_FAST |-> fast_on && slow_on && !sub_clk_en_o && !(sys_clk_en_o && sel_act_q == `SCM_SEL_SUB);
  endproperty
  a_idle_fast: assert property (p_idle_fast) else $error("fast-only idle clocks wrong");
  property p_normal;
    mode_q == SCM_RUN && sel_act_q != `SCM_SEL_SUB && sys_clk_en_o |-> fast_tick && fast_on;
  endproperty
  a_normal: assert property (p_normal) else $error("normal system tick not from fast");
  property p_slow;
    mode_q == SCM_RUN && sel_act_q == `SCM_SEL_SUB && sys_clk_en_o |-> slow_tick;
  endproperty
  a_slow: assert property (p_slow) else $error("slow system tick not from sub");
  property p_stable;
    !fast_on ##1 fast_on |-> !hs_stable;
  endproperty
  a_stable: assert property (p_stable) else $error("stable flag not cleared on start");
  property p_glitch;
    sys_clk_en_o |-> gap_q >= 16'(FAST_PER - 1);
  endproperty
  a_glitch: assert property (p_glitch) else $error("system tick gap too short");

  c_sleep_wake: cover property (@(posedge clk_i) mode_q == SCM_SLEEP ##1 mode_q == SCM_RUN);
  c_switch:     cover property (@(posedge clk_i) sw_q == SCM_SW_NEW && new_tick);
  c_idle_both:  cover property (@(posedge clk_i) mode_q == SCM_IDLE_BOTH && sys_clk_en_o);
endmodule
`default_nettype wire

/* dv/scm_cpu_model.sv */
/*
  CPU side partner: turns a bench halt request into one halt pulse.
  Assumes it shares clk_i with the block.
*/
`default_nettype none
module scm_cpu_model (
  input  wire logic clk_i,     // Block clock
  input  wire logic rst_i,     // Sync reset
  input  wire logic req_i,     // Bench halt request, level
  input  wire logic cpu_run_i, // CPU clocked
  output logic      halt_o     // One-cycle halt pulse
);
  timeunit 1ns;
  timeprecision 1ps;
  logic req_q;

  // ------------------------------------------------
  // Halt pulse
  // ------------------------------------------------
  // A stopped CPU executes no halt, so no pulse then
  always_ff @(posedge clk_i) begin
    req_q  <= rst_i ? 1'b0 : req_i;
    halt_o <= !rst_i && req_i && !req_q && cpu_run_i;
  end
endmodule
`default_nettype wire

/* dv/tb_scm_top.sv */
/*
  Self-checking bench of scm_top: registers, clock select, halt modes.
  Assumes a 200 MHz clock and the slow period cut to 50 cycles.
*/
`default_nettype none
`include "scm_params.svh"
module tb_scm_top;
  timeunit 1ns;
  timeprecision 1ps;
  import scm_pkg::*;
  localparam int SP = 50;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc, stb, we, ack, halt, wake, wdt, req;
  logic        run, sys_t, fast_t, sub_t, slow_internal_rc_t, irq;
  logic [7:0]  adr;
  logic [31:0] wdat, rdat, q;
  logic [6:0]  per;
  logic [3:0]  sel;
  scm_mode_t   mode;
  scm_mode_t   em [4] = '{SCM_SLEEP, SCM_IDLE_SLOW, SCM_IDLE_FAST, SCM_IDLE_BOTH};
  int          n_errors = 0;
  int          n_tests = 0;
  int          g, f, s, y, l, p;

  always #2.5 clk_i = ~clk_i;

  scm_top #(.SLOW_PER(SP)) dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .halt_i(halt), .wake_i(wake), .wdt_en_i(wdt), .cpu_run_o(run), .sys_clk_en_o(sys_t),
    .fast_clk_en_o(fast_t), .sub_clk_en_o(sub_t), .slow_internal_rc_clk_en_o(slow_internal_rc_t),
    .periph_en_o(per), .mode_o(mode), .irq_o(irq));

  scm_cpu_model cpu (.clk_i(clk_i), .rst_i(rst_i), .req_i(req), .cpu_run_i(run), .halt_o(halt));

  // ------------------------------------------------
  // Shared tasks
  // ------------------------------------------------
  task automatic tally_and_finish();
    if (n_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Classic cycle: hold until ack is sampled, then one idle cycle
  // Waits for ack however long it takes; only the watchdog ends a hang
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do
      @(posedge clk_i);
    while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
    chk("ack drop", 32'(ack), 32'h0);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    xfer(1'b0, a, 32'h0);
    chk("read", q, exp);
  endtask

  // Cycles up to and including the next system tick
  task automatic tick(output int n);
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (sys_t !== 1'b1 && n < 5000);
  endtask

  task automatic win(input int n);
    f = 0; s = 0; y = 0; l = 0; p = 0;
    repeat (n) begin
      @(posedge clk_i);
      f += int'(fast_t === 1'b1);
      p += int'(per[1] === 1'b1);
      s += int'(sub_t === 1'b1);
      y += int'(sys_t === 1'b1);
      l += int'(slow_internal_rc_t === 1'b1);
    end
  endtask

  // ------------------------------------------------
  // Main sequence
  // ------------------------------------------------
  initial begin
    {cyc, stb, we, wake, wdt, req} = '0;
    sel  = 4'hf;
    adr  = 8'h00;
    wdat = 32'h0;
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(`SCM_OFF_CTRL, 32'h0);
    rd(`SCM_OFF_OSC, 32'h1);
    rd(`SCM_OFF_MODE, 32'h0);
    rd(`SCM_OFF_IRQ_MSK, 32'h0);
    xfer(1'b1, 8'h20, 32'hff);
    rd(8'h20, 32'h0);
    repeat (3300) @(posedge clk_i);
    rd(`SCM_OFF_OSC, 32'h3);
    rd(`SCM_OFF_IRQ_STS, 32'h1);
    chk("irq masked", 32'(irq), 32'h0);
    xfer(1'b1, `SCM_OFF_IRQ_MSK, 32'h1);
    chk("irq on", 32'(irq), 32'h1);
    xfer(1'b1, `SCM_OFF_IRQ_STS, 32'h1);
    chk("irq off", 32'(irq), 32'h0);
    rd(`SCM_OFF_IRQ_STS, 32'h0);
    xfer(1'b1, `SCM_OFF_IRQ_MSK, 32'h0);
    // Lane 0 off: the write must be dropped
    sel <= 4'he;
    xfer(1'b1, `SCM_OFF_IRQ_MSK, 32'h7);
    sel <= 4'hf;
    rd(`SCM_OFF_IRQ_MSK, 32'h0);
    // Every select code; four ticks let the switch finish
    for (int k = 0; k < 8; k++) begin
      xfer(1'b1, `SCM_OFF_CTRL, 32'(k << 5));
      repeat (4) tick(g);
      tick(g);
      chk("sys gap", 32'(g), (k == 7) ? 32'(SP) : 32'(25 << k));
      rd(`SCM_OFF_MODE, 32'(k << 4));
    end
    // Slow mode with the fast oscillator off, then back on
    xfer(1'b1, `SCM_OFF_OSC, 32'h0);
    win(200);
    chk("fast off", 32'(f), 32'h0);
    chk("periph off", 32'(p), 32'h0);
    chk("sys on sub", 32'(y != 0), 32'h1);
    rd(`SCM_OFF_OSC, 32'h0);
    xfer(1'b1, `SCM_OFF_OSC, 32'h1);
    rd(`SCM_OFF_OSC, 32'h1);
    win(400);
    chk("fast in slow", 32'(f != 0), 32'h1);
    chk("periph in slow", 32'(p == f / 2 || p == (f + 1) / 2), 32'h1);
    repeat (3300) @(posedge clk_i);
    rd(`SCM_OFF_OSC, 32'h3);
    // Every keep combination, with fast and slow system clock
    for (int sl = 0; sl < 2; sl++) begin
      for (int k = 0; k < 4; k++) begin
        wdt <= (sl == 1);
        xfer(1'b1, `SCM_OFF_CTRL, 32'(((sl * 7) << 5) | k));
        repeat (300) @(posedge clk_i);
        req <= 1'b1;
        @(posedge clk_i);
        req <= 1'b0;
        repeat (3) @(posedge clk_i);
        chk("mode", 32'(mode), 32'(em[k]));
        chk("cpu stop", 32'(run), 32'h0);
        win(400);
        chk("fast", 32'(f != 0), 32'(k[1]));
        chk("periph", 32'(p == f / 2 || p == (f + 1) / 2), 32'h1);
        chk("sub", 32'(s != 0), 32'(k[0]));
        chk("sys", 32'(y != 0), 32'((sl == 1) ? k[0] : k[1]));
        chk("slow_internal_rc", 32'(l != 0), 32'((k == 0) ? sl : 1));
        wake <= 1'b1;
        @(posedge clk_i);
        wake <= 1'b0;
        @(posedge clk_i);
        chk("wake", 32'(mode), 32'(SCM_RUN));
        chk("cpu run", 32'(run), 32'h1);
      end
    end
    // Stable rose, halt entered and wake seen are all still pending
    rd(`SCM_OFF_IRQ_STS, 32'h7);
    tally_and_finish();
  end

  initial begin
    repeat (80000) @(posedge clk_i);
    n_errors++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
